// [fbex_defs.svh]
// Constants of the flag and branch execution unit.
// Assumes inclusion by bare name from the package and the design files.
`ifndef FBEX_DEFS_SVH
`define FBEX_DEFS_SVH
`define FBEX_DATA_W        24
`define FBEX_PC_W          13
`define FBEX_PC_LIMIT      13'h1FFF
`define FBEX_BIT_IDX_MAX   5'h17
`define FBEX_LEN_FLAG      2'h1
`define FBEX_CYC_FLAG      3'h1
`define FBEX_LEN_REL       2'h2
`define FBEX_CYC_REL       3'h3
`define FBEX_LEN_ABS       2'h3
`define FBEX_CYC_ABS       3'h4
`define FBEX_SIGN_BIT      23
`define FBEX_ZERO_WORD     24'h000000
`endif

// [fbex_pkg.sv]
// Types of the flag and branch execution unit.
// Assumes fbex_defs.svh is on the include path.
`include "fbex_defs.svh"
package fbex_pkg;
   typedef enum logic [2:0] {
      FBEX_OP_NONE, FBEX_OP_GETFLAG, FBEX_OP_JUMP,
      FBEX_OP_BIT_LOW, FBEX_OP_BIT_HIGH, FBEX_OP_NO_CARRY
   } fbex_op_t;
   typedef enum logic [1:0] {FBEX_REG_X, FBEX_REG_Y, FBEX_REG_Z, FBEX_REG_R} fbex_reg_sel_t;
   typedef struct packed {
      logic                     valid;
      fbex_op_t                 op;
      logic                     absolute;
      fbex_reg_sel_t            reg_sel;
      logic [4:0]               bit_idx;
      logic [`FBEX_PC_W-1:0]    target;
      logic [`FBEX_PC_W-1:0]    pc;
   } fbex_instr_t;
   typedef struct packed {
      logic [`FBEX_DATA_W-1:0]  x;
      logic [`FBEX_DATA_W-1:0]  y;
      logic [`FBEX_DATA_W-1:0]  z;
      logic [`FBEX_DATA_W-1:0]  r;
   } fbex_regs_t;
   typedef struct packed {
      logic                     sign;
      logic                     nonzero;
      logic                     carry;
   } fbex_flags_t;
   typedef struct packed {
      logic                     done;
      logic                     pc_load;
      logic [`FBEX_PC_W-1:0]    pc_next;
      logic                     flags_we;
      fbex_flags_t              flags;
      logic [1:0]               length;
      logic [2:0]               cycles;
      logic                     illegal;
   } fbex_result_t;
endpackage : fbex_pkg

// [fbex_regpick.sv]
// Picks one working register and tests one of its bits.
// Assumes a registered file of four working registers on the same clock.
`include "fbex_defs.svh"
`default_nettype none
module fbex_regpick
   import fbex_pkg::*;
(
   input  wire fbex_pkg::fbex_regs_t    regs,
   input  wire fbex_pkg::fbex_reg_sel_t sel,
   input  wire logic [4:0]              bit_idx,
   output logic [`FBEX_DATA_W-1:0]      word,
   output logic                         bit_val,
   output logic                         idx_bad
);
   always_comb begin
      case (sel)
         FBEX_REG_X: word = regs.x;
         FBEX_REG_Y: word = regs.y;
         FBEX_REG_Z: word = regs.z;
         default:    word = regs.r;
      endcase
   end
   assign idx_bad = (bit_idx > `FBEX_BIT_IDX_MAX);
   // Out-of-range index reads as zero rather than wrapping
   assign bit_val = idx_bad ? 1'b0 : word[bit_idx];
endmodule : fbex_regpick
`default_nettype wire

// [fbex_exec.sv]
// Flag-from-register and jump execution for the measurement CPU.
// Assumes decode hands one instruction per valid pulse with its own pc.
`include "fbex_defs.svh"
`default_nettype none
module fbex_exec (
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   input  wire fbex_pkg::fbex_instr_t instr,
   input  wire fbex_pkg::fbex_regs_t  regs,
   input  wire fbex_pkg::fbex_flags_t flags_in,
   output var fbex_pkg::fbex_result_t result
);
   import fbex_pkg::*;

   typedef struct packed {
      logic [1:0]   rst_sync;
      fbex_result_t res;
   } fbex_state_t;

   fbex_state_t             st_q;
   fbex_state_t             st_d;
   logic                    rst_int_b;
   logic [`FBEX_DATA_W-1:0] word;
   logic                    bit_val;
   logic                    idx_bad;

   // Instruction class, at most one op class set per cycle; is_bit_op, is_branch and is_known group them
   logic                    is_flag;
   logic                    is_jump;
   logic                    is_bit_low;
   logic                    is_bit_high;
   logic                    is_no_carry;
   logic                    is_bit_op;
   logic                    is_branch;
   logic                    is_known;

   // Per-instruction outcome, settled before the clock edge
   logic                    take;
   logic                    bad;
   logic [1:0]              len;
   logic [2:0]              cyc;
   logic [`FBEX_PC_W-1:0]   fall_pc;
   logic [`FBEX_PC_W-1:0]   dest_pc;
   fbex_flags_t             flags_new;

   assign rst_int_b = st_q.rst_sync[1];

   fbex_regpick i_fbex_regpick (
      .regs    (regs),
      .sel     (instr.reg_sel),
      .bit_idx (instr.bit_idx),
      .word    (word),
      .bit_val (bit_val),
      .idx_bad (idx_bad)
   );

   // Decode: unused op codes fall to no class and give no done
   always_comb begin
      is_flag     = 1'b0;
      is_jump     = 1'b0;
      is_bit_low  = 1'b0;
      is_bit_high = 1'b0;
      is_no_carry = 1'b0;
      case (instr.op)
         FBEX_OP_GETFLAG: begin
            is_flag = 1'b1;
         end
         FBEX_OP_JUMP: begin
            is_jump = 1'b1;
         end
         FBEX_OP_BIT_LOW: begin
            is_bit_low = 1'b1;
         end
         FBEX_OP_BIT_HIGH: begin
            is_bit_high = 1'b1;
         end
         FBEX_OP_NO_CARRY: begin
            is_no_carry = 1'b1;
         end
         default: begin
            is_flag = 1'b0;
         end
      endcase
   end

   assign is_bit_op = is_bit_low | is_bit_high;
   assign is_branch = is_jump | is_bit_op | is_no_carry;
   assign is_known  = is_flag | is_branch;

   // Encoded size and execution time of each variant
   // Bit tests only exist in the long form, so the absolute flag is ignored for them
   always_comb begin
      if (!is_known) begin
         len = 2'h0;
         cyc = 3'h0;
      end else if (is_flag) begin
         len = `FBEX_LEN_FLAG;
         cyc = `FBEX_CYC_FLAG;
      end else if (is_bit_op) begin
         len = `FBEX_LEN_ABS;
         cyc = `FBEX_CYC_ABS;
      end else if (instr.absolute) begin
         len = `FBEX_LEN_ABS;
         cyc = `FBEX_CYC_ABS;
      end else begin
         len = `FBEX_LEN_REL;
         cyc = `FBEX_CYC_REL;
      end
   end

   // Branch condition for each kind of jump
   always_comb begin
      take = 1'b0;
      case (instr.op)
         FBEX_OP_JUMP: begin
            take = 1'b1;
         end
         FBEX_OP_BIT_LOW: begin
            take = ~bit_val;
         end
         FBEX_OP_BIT_HIGH: begin
            take = bit_val;
         end
         FBEX_OP_NO_CARRY: begin
            take = ~flags_in.carry;
         end
         default: begin
            take = 1'b0;
         end
      endcase
   end

   // Top address 1FFF of the 8 kB space is refused for FBEX_OP_JUMP only, not for bit or carry branches; a refused jump loads nothing
   assign bad = (is_jump & (instr.target == `FBEX_PC_LIMIT))
              | (is_bit_op & idx_bad);

   // Untaken branch falls through past its own bytes
   assign fall_pc = instr.pc + {{(`FBEX_PC_W-2){1'b0}}, len};
   assign dest_pc = (take & ~bad) ? instr.target : fall_pc;

   // Only flags are written; the register file stays untouched
   always_comb begin
      flags_new = flags_in;
      if (is_flag) begin
         flags_new.sign    = word[`FBEX_SIGN_BIT];
         flags_new.nonzero = (word != `FBEX_ZERO_WORD);
      end
   end

   // Pulses drop every cycle; levels hold until the next valid instruction
   always_comb begin
      st_d = st_q;
      st_d.rst_sync = {st_q.rst_sync[0], 1'b1};
      st_d.res.done     = 1'b0;
      st_d.res.pc_load  = 1'b0;
      st_d.res.flags_we = 1'b0;
      st_d.res.illegal  = 1'b0;
      if (instr.valid) begin
         st_d.res.flags   = flags_new;
         st_d.res.pc_next = dest_pc;
         st_d.res.length  = len;
         st_d.res.cycles  = cyc;
         if (is_known) begin
            st_d.res.done     = 1'b1;
            st_d.res.flags_we = is_flag;
            st_d.res.illegal  = bad;
            st_d.res.pc_load  = ~bad;
         end
      end
      // Outputs stay quiet until the synchronised reset has let go
      if (!rst_int_b) begin
         st_d.res = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign result = st_q.res;
endmodule : fbex_exec
`default_nettype wire

// [fbex_checker.sv]
// Concurrent checks on the ports of the flag and branch execution unit.
// Assumes fbex_pkg is compiled first; bound into every fbex_exec.
`include "fbex_defs.svh"
`default_nettype none
module fbex_checker
   import fbex_pkg::*;
(
   input wire logic                   clk,
   input wire logic                   rst_b,
   input wire fbex_pkg::fbex_instr_t  instr,
   input wire fbex_pkg::fbex_regs_t   regs,
   input wire fbex_pkg::fbex_flags_t  flags_in,
   input wire fbex_pkg::fbex_result_t result
);
   logic [23:0] w;
   logic        b;
   // x sits in the top slice of the packed file
   assign w = regs[95-24*instr.reg_sel -: 24];
   assign b = w[instr.bit_idx];
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_op(fbex_op_t o);
      instr.valid && instr.op == o;
   endsequence
   sequence s_ok;
      instr.bit_idx <= `FBEX_BIT_IDX_MAX;
   endsequence
   flag_sign_a:
      assert property (s_op(FBEX_OP_GETFLAG) |=> result.flags_we
         && result.flags.sign == $past(w[23])) else $error("sign flag wrong");
   flag_nz_a:
      assert property (s_op(FBEX_OP_GETFLAG) |=> result.flags.nonzero == ($past(w) != 0))
         else $error("nonzero flag wrong");
   jump_load_a:
      assert property (s_op(FBEX_OP_JUMP) ##0 instr.target != `FBEX_PC_LIMIT |=>
         result.pc_load && result.pc_next == $past(instr.target)) else $error("jump lost");
   jump_range_a:
      assert property (s_op(FBEX_OP_JUMP) ##0 instr.target == `FBEX_PC_LIMIT |=>
         result.illegal && !result.pc_load) else $error("jump range");
   bit_low_a:
      assert property (s_op(FBEX_OP_BIT_LOW) ##0 s_ok |=> result.pc_next == ($past(b) ?
         $past(instr.pc + 13'h3) : $past(instr.target))) else $error("bit low");
   bit_high_a:
      assert property (s_op(FBEX_OP_BIT_HIGH) ##0 s_ok |=> result.pc_next == ($past(b) ?
         $past(instr.target) : $past(instr.pc + 13'h3))) else $error("bit high");
   no_carry_a:
      assert property (s_op(FBEX_OP_NO_CARRY) |=> result.pc_next == ($past(flags_in.carry) ?
         $past(instr.pc + (instr.absolute ? 13'h3 : 13'h2)) : $past(instr.target)))
         else $error("no carry");
   keep_flags_a:
      assert property (instr.valid && instr.op > FBEX_OP_GETFLAG |=> !result.flags_we
         && result.flags == $past(flags_in)) else $error("flags touched");
   none_refused_a:
      assert property (s_op(FBEX_OP_NONE) |=> !result.done && !result.pc_load)
         else $error("empty op answered");
   bit_range_a:
      assert property (instr.valid && (instr.op == FBEX_OP_BIT_LOW
         || instr.op == FBEX_OP_BIT_HIGH) && !(instr.bit_idx <= `FBEX_BIT_IDX_MAX)
         |=> result.done && result.illegal && !result.pc_load) else $error("bit range");
endmodule // fbex_checker
bind fbex_exec fbex_checker i_fbex_checker (.clk(clk), .rst_b(rst_b), .instr(instr),
   .regs(regs), .flags_in(flags_in), .result(result));
`default_nettype wire

// [tb_flag_and_branch_execution.sv]
// Self-checking bench for fbex_exec, one scenario task per behaviour.
// Assumes package, design and checker files are compiled first.
`default_nettype none
module tb_flag_and_branch_execution
   import fbex_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic         clk = 1'b0;
   logic         rst_b = 1'b0;
   fbex_instr_t  ins = '0;
   fbex_regs_t   regs = {24'h800000, 24'h000000, 24'h000001, 24'h7FFFFF};
   fbex_flags_t  fl = 3'h3;
   fbex_result_t res;
   int           err_count = 0;
   int           num_checks = 0;
   always #20 clk = ~clk;
   fbex_exec i_fbex_exec (.clk(clk), .rst_b(rst_b), .instr(ins), .regs(regs),
      .flags_in(fl), .result(res));
   task automatic chk(string n, logic [12:0] e, logic [12:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Length 0 marks an instruction that must be refused
   task automatic go(fbex_op_t op, logic ab, fbex_reg_sel_t s, logic [4:0] ix,
      logic [12:0] t, logic [12:0] pn, logic [2:0] ln, logic [2:0] cy);
      @(posedge clk);
      ins <= '{1'b1, op, ab, s, ix, t, 13'h100};
      @(posedge clk);
      ins.valid <= 1'b0;
      #1;
      chk("done", 1, res.done);
      chk("illegal", ln == 0, res.illegal);
      chk("pc_load", ln != 0, res.pc_load);
      if (ln != 0) begin
         chk("pc_next", pn, res.pc_next);
         chk("length", ln, res.length);
         chk("cycles", cy, res.cycles);
         chk("flags_we", op == FBEX_OP_GETFLAG, res.flags_we);
         if (op != FBEX_OP_GETFLAG) chk("flags", fl, res.flags);
      end
   endtask
   task automatic t_flag;
      logic [23:0] v;
      for (int i = 0; i < 4; i++) begin
         v = regs[95-24*i -: 24];
         go(FBEX_OP_GETFLAG, 0, fbex_reg_sel_t'(i), 0, 0, 13'h101, 1, 1);
         chk("sign", v[23], res.flags.sign);
         chk("nonzero", v != 0, res.flags.nonzero);
         chk("carry", fl.carry, res.flags.carry);
      end
   endtask
   // An empty op code must give no answer at all
   task automatic t_none;
      @(posedge clk);
      ins <= '{1'b1, FBEX_OP_NONE, 1'b0, FBEX_REG_X, 5'h0, 13'h40, 13'h100};
      @(posedge clk);
      ins.valid <= 1'b0;
      #1;
      chk("none_done", 0, res.done);
      chk("none_pc_load", 0, res.pc_load);
   endtask
   task automatic t_jump;
      go(FBEX_OP_JUMP, 0, FBEX_REG_X, 0, 13'h0, 13'h0, 2, 3);
      go(FBEX_OP_JUMP, 1, FBEX_REG_X, 0, 13'h1FFE, 13'h1FFE, 3, 4);
      go(FBEX_OP_JUMP, 1, FBEX_REG_X, 0, 13'h1FFF, 0, 0, 0);
   endtask
   task automatic t_bit;
      go(FBEX_OP_BIT_LOW, 1, FBEX_REG_X, 5'h0, 13'h40, 13'h40, 3, 4);
      go(FBEX_OP_BIT_LOW, 1, FBEX_REG_X, 5'h17, 13'h40, 13'h103, 3, 4);
      go(FBEX_OP_BIT_HIGH, 1, FBEX_REG_X, 5'h17, 13'h40, 13'h40, 3, 4);
      go(FBEX_OP_BIT_HIGH, 1, FBEX_REG_Z, 5'h1, 13'h40, 13'h103, 3, 4);
      go(FBEX_OP_BIT_HIGH, 1, FBEX_REG_X, 5'h18, 13'h40, 0, 0, 0);
      go(FBEX_OP_BIT_LOW, 1, FBEX_REG_Y, 5'h1F, 13'h40, 0, 0, 0);
   endtask
   task automatic t_carry;
      go(FBEX_OP_NO_CARRY, 0, FBEX_REG_X, 0, 13'h40, 13'h102, 2, 3);
      @(posedge clk);
      fl <= 3'h2;
      go(FBEX_OP_NO_CARRY, 1, FBEX_REG_X, 0, 13'h40, 13'h40, 3, 4);
      go(FBEX_OP_NO_CARRY, 0, FBEX_REG_X, 0, 13'h1FF0, 13'h1FF0, 2, 3);
   endtask
   task automatic summarize;
      if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      t_flag;
      t_none;
      t_jump;
      t_bit;
      t_carry;
      summarize;
   end
endmodule // tb_flag_and_branch_execution
`default_nettype wire
